// ==== logic/liq_defs.svh ====
/*
  liq_defs.svh: offsets, field positions, link layout and codes for the
  linked queue engine.
  assumes: included by the engine and the testbench; defines only.
*/
`ifndef LIQ_DEFS_SVH
`define LIQ_DEFS_SVH

// axi4-lite register byte offsets
`define LIQ_OFF_CTRL     8'h00
`define LIQ_OFF_STATUS   8'h04
`define LIQ_OFF_OPA      8'h08
`define LIQ_OFF_OPB      8'h0c
`define LIQ_OFF_CC       8'h10
`define LIQ_OFF_FAULT    8'h14
// ctrl fields: bit 0 start, bits 15:8 opcode
`define LIQ_CTRL_START   0
`define LIQ_CTRL_OP_LSB  8
// status fields
`define LIQ_ST_BUSY      0
`define LIQ_ST_DONE      1
// opcodes
`define LIQ_OP_INS_PLAIN 8'h0e
`define LIQ_OP_REM_PLAIN 8'h0f
`define LIQ_OP_INS_FRONT 8'h5c
// fault codes
`define LIQ_FLT_NONE     2'h0
`define LIQ_FLT_RSVD     2'h1
`define LIQ_FLT_ACCESS   2'h2
`define LIQ_FLT_ILLOP    2'h3
// link layout
`define LIQ_BACK_OFS     32'h0000_0004
`define LIQ_BUSY_BIT     0
`endif

// ==== logic/liq_pkg.sv ====
/*
  liq_pkg.sv: types of the linked queue engine.
  assumes: liq_defs.svh beside it.
*/
`default_nettype none
package liq_pkg;
  typedef enum logic [8:0] {
    LIQ_IDLE  = 9'h001,
    LIQ_LOCK  = 9'h002,
    LIQ_REL   = 9'h004,
    LIQ_CHK   = 9'h008,
    LIQ_RD    = 9'h010,
    LIQ_WR    = 9'h020,
    LIQ_CLR   = 9'h040,
    LIQ_FIN   = 9'h080,
    LIQ_WAITM = 9'h100
  } liq_state_e;
  typedef logic [31:0] liq_word_t;
endpackage
`default_nettype wire

// ==== logic/liq_engine.sv ====
/*
  liq_engine.sv: queue instruction engine. software loads operands and an
  opcode over axi4-lite and starts it; the engine walks memory through a
  simple request/acknowledge port and posts condition codes and faults.
  assumes: mem_ack pulses on the same clock once per request; an
  interlocked read holds the memory lock until the interlocked write; the
  memory answers mem_err when an address cannot be written (access check).
*/
`default_nettype none
`include "liq_defs.svh"

// Notes on behaviour
// - absolute link pair: low longword next entry, high longword previous
// - header is a link pair: forward to head entry, backward to tail
// - forward link of the last entry points back at the header
// - plain insert links entry right after the predecessor operand
// - plain remove unlinks the entry operand from its queue
// - plain queue operations accept any byte address, no alignment check
// - plain insert and remove run to the end without interruption
// - self-relative links hold signed displacements from the entry itself
// - only four self-relative operations, each interlocked; the engine serves only opcode 5c, the others fault as illegal opcodes
// - self-relative entries sit on eight-byte boundaries
// - header forward link read interlocked, lock freed by interlocked write
// - header bit 0 is a busy flag, set during work, cleared after
// - busy already set: write snapshot back, end, c=1, n z v clear
// - busy and bits 2:1 clear: write snapshot or 1, freeing lock and setting busy
// - check entry and target writable and aligned before links change
// - link entry after header, clear busy; z if entry links equal
// - busy flag excludes other interlocked users for the whole insert
// - failed access check raises memory fault though nothing started
// - reserved operand: misaligned addresses, header bits 2:1, header equals entry
// - opcode 5c is the interlocked front insert: entry then header
module liq_engine
  import liq_pkg::*;
(
  input  wire logic        aclk,          // 250 mhz clock
  input  wire logic        aresetn,       // synchronous reset, low
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output var  logic        s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // byte enables
  input  wire logic        s_axi_wvalid,  // write data valid
  output var  logic        s_axi_wready,  // write data ready
  output var  logic [1:0]  s_axi_bresp,   // write response
  output var  logic        s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output var  logic        s_axi_arready, // read address ready
  output var  logic [31:0] s_axi_rdata,   // read data
  output var  logic [1:0]  s_axi_rresp,   // read response
  output var  logic        s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output var  logic        mem_req,       // memory request, held until ack
  output var  logic        mem_we,        // write when high
  output var  logic        mem_lock,      // interlocked access
  output var  logic        mem_probe,     // write-access check, no data change
  output var  logic [31:0] mem_addr,      // byte address
  output var  logic [31:0] mem_wdata,     // write data
  input  wire logic        mem_ack,       // one-cycle completion
  input  wire logic        mem_err,       // access cannot complete, with ack
  input  wire logic [31:0] mem_rdata      // read data, with ack
);

  liq_state_e state_r;
  liq_word_t  opa_r, opb_r, snap_r, succ_r, ent_f_r, ent_b_r;
  logic [7:0] op_r;
  logic [3:0] cc_r;                        // n z v c
  logic [1:0] fault_r;
  logic       done_r;
  logic [2:0] step_r;
  logic       start_w;
  logic       aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       wr_go;

  // write side: capture address and data in either order, then commit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign wr_go   = aw_hold_r && w_hold_r && !s_axi_bvalid;
  // starting while busy is ignored; the instruction cannot be interrupted
  assign start_w = wr_go && aw_addr_r == `LIQ_OFF_CTRL && w_strb_r[0] &&
                   w_data_r[`LIQ_CTRL_START] && state_r == LIQ_IDLE;

  // operand and opcode registers; writes ignored while an instruction runs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      opa_r <= 32'h0000_0000;
      opb_r <= 32'h0000_0000;
      op_r  <= 8'h00;
    end
    else if (wr_go && state_r == LIQ_IDLE)
    begin
      if (aw_addr_r == `LIQ_OFF_OPA)
        opa_r <= w_data_r;
      if (aw_addr_r == `LIQ_OFF_OPB)
        opb_r <= w_data_r;
      if (aw_addr_r == `LIQ_OFF_CTRL && w_strb_r[1])
        op_r <= w_data_r[`LIQ_CTRL_OP_LSB +: 8];
    end
  end

  // read side: one word per request, unmapped reads answer zero, okay
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        unique case (s_axi_araddr)
          `LIQ_OFF_CTRL:   s_axi_rdata <= {16'h0000, op_r, 8'h00};
          `LIQ_OFF_STATUS: s_axi_rdata <= {30'h0, done_r, state_r != LIQ_IDLE};
          `LIQ_OFF_OPA:    s_axi_rdata <= opa_r;
          `LIQ_OFF_OPB:    s_axi_rdata <= opb_r;
          `LIQ_OFF_CC:     s_axi_rdata <= {28'h0, cc_r};
          `LIQ_OFF_FAULT:  s_axi_rdata <= {30'h0, fault_r};
          default:         s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // memory sequencer. plain ops: opa entry, opb predecessor (insert).
  // interlocked insert: opa entry, opb header.
  // the header read and its write-back are adjacent states, so no other
  // header access can slip in while the bus lock is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r   <= LIQ_IDLE;
      step_r    <= 3'h0;
      snap_r    <= 32'h0000_0000;
      succ_r    <= 32'h0000_0000;
      ent_f_r   <= 32'h0000_0000;
      ent_b_r   <= 32'h0000_0000;
      cc_r      <= 4'h0;
      fault_r   <= `LIQ_FLT_NONE;
      done_r    <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_lock  <= 1'b0;
      mem_probe <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end
    else
    begin
      unique case (state_r)
        LIQ_IDLE:
        begin
          if (start_w)
          begin
            done_r  <= 1'b0;
            fault_r <= `LIQ_FLT_NONE;
            step_r  <= 3'h0;
            if (op_r == `LIQ_OP_INS_FRONT)
            begin
              // misaligned or aliased operands fault before any access
              if (opa_r[2:0] != 3'h0 || opb_r[2:0] != 3'h0 || opa_r == opb_r)
              begin
                fault_r <= `LIQ_FLT_RSVD;
                state_r <= LIQ_FIN;
              end
              else
              begin
                mem_req  <= 1'b1;
                mem_we   <= 1'b0;
                mem_lock <= 1'b1;
                mem_addr <= opb_r;
                state_r  <= LIQ_LOCK;
              end
            end
            else if (op_r == `LIQ_OP_INS_PLAIN || op_r == `LIQ_OP_REM_PLAIN)
            begin
              // plain ops take any byte address: no alignment check here
              mem_req  <= 1'b1;
              mem_we   <= 1'b0;
              mem_lock <= 1'b0;
              mem_addr <= (op_r == `LIQ_OP_INS_PLAIN) ? opb_r : opa_r;
              state_r  <= LIQ_RD;
            end
            else
            begin
              // self-relative tail and remove forms are not served here
              fault_r <= `LIQ_FLT_ILLOP;
              state_r <= LIQ_FIN;
            end
          end
        end
        LIQ_LOCK:
        begin
          if (mem_ack)
          begin
            snap_r    <= mem_rdata;
            mem_we    <= 1'b1;
            mem_lock  <= 1'b1;
            mem_addr  <= opb_r;
            state_r   <= LIQ_REL;
            if (mem_rdata[`LIQ_BUSY_BIT] || mem_rdata[2:1] != 2'h0)
              mem_wdata <= mem_rdata;
            else
              mem_wdata <= mem_rdata | 32'h0000_0001;
          end
        end
        LIQ_REL:
        begin
          if (mem_ack)
          begin
            mem_lock <= 1'b0;
            if (snap_r[`LIQ_BUSY_BIT])
            begin
              mem_req <= 1'b0;
              cc_r    <= 4'b0001;
              state_r <= LIQ_FIN;
            end
            else if (snap_r[2:1] != 2'h0)
            begin
              mem_req <= 1'b0;
              fault_r <= `LIQ_FLT_RSVD;
              state_r <= LIQ_FIN;
            end
            else
            begin
              // probe entry, then old head (header plus displacement)
              mem_we    <= 1'b0;
              mem_probe <= 1'b1;
              mem_addr  <= opa_r;
              step_r    <= 3'h0;
              state_r   <= LIQ_CHK;
            end
          end
        end
        LIQ_CHK:
        begin
          if (mem_ack)
          begin
            if (mem_err || (step_r == 3'h1 && mem_addr[2:0] != 3'h0))
            begin
              // drop the busy flag so the queue is usable after the fault
              mem_probe <= 1'b0;
              mem_we    <= 1'b1;
              mem_addr  <= opb_r;
              mem_wdata <= snap_r;
              fault_r   <= `LIQ_FLT_ACCESS;
              state_r   <= LIQ_CLR;
            end
            else if (step_r == 3'h0)
            begin
              mem_addr <= opb_r + snap_r;
              step_r   <= 3'h1;
            end
            else
            begin
              // entry links as displacements from the entry itself
              mem_probe <= 1'b0;
              mem_we    <= 1'b1;
              mem_addr  <= opa_r;
              mem_wdata <= opb_r + snap_r - opa_r;
              ent_f_r   <= opb_r + snap_r - opa_r;
              ent_b_r   <= opb_r - opa_r;
              step_r    <= 3'h0;
              state_r   <= LIQ_WR;
            end
          end
        end
        LIQ_RD:
        begin
          // plain: step0 reads the forward link of pred (insert) or entry
          if (mem_ack)
          begin
            if (mem_err)
            begin
              mem_req <= 1'b0;
              fault_r <= `LIQ_FLT_ACCESS;
              state_r <= LIQ_FIN;
            end
            else if (step_r == 3'h0)
            begin
              succ_r   <= mem_rdata;
              mem_addr <= opa_r + `LIQ_BACK_OFS;
              step_r   <= 3'h1;
            end
            else
            begin
              ent_b_r <= mem_rdata;
              mem_we  <= 1'b1;
              step_r  <= 3'h0;
              state_r <= LIQ_WAITM;
              if (op_r == `LIQ_OP_INS_PLAIN)
              begin
                mem_addr  <= opa_r;
                mem_wdata <= succ_r;
              end
              else
              begin
                // predecessor's forward link takes our successor
                mem_addr  <= mem_rdata;
                mem_wdata <= succ_r;
              end
            end
          end
        end
        LIQ_WAITM:
        begin
          // plain write chain; each step issued on the previous ack
          if (mem_ack)
          begin
            step_r <= step_r + 3'h1;
            if (op_r == `LIQ_OP_INS_PLAIN)
            begin
              unique case (step_r)
                3'h0:
                begin
                  mem_addr  <= opa_r + `LIQ_BACK_OFS;
                  mem_wdata <= opb_r;
                end
                3'h1:
                begin
                  mem_addr  <= succ_r + `LIQ_BACK_OFS;
                  mem_wdata <= opa_r;
                end
                3'h2:
                begin
                  mem_addr  <= opb_r;
                  mem_wdata <= opa_r;
                end
                default:
                begin
                  mem_req <= 1'b0;
                  cc_r    <= {$signed(succ_r) < $signed(opb_r), succ_r == opb_r,
                              1'b0, succ_r < opb_r};
                  state_r <= LIQ_FIN;
                end
              endcase
            end
            else if (step_r == 3'h0)
            begin
              mem_addr  <= succ_r + `LIQ_BACK_OFS;
              mem_wdata <= ent_b_r;
            end
            else
            begin
              mem_req <= 1'b0;
              cc_r    <= {$signed(succ_r) < $signed(ent_b_r), succ_r == ent_b_r,
                          opa_r == succ_r, succ_r < ent_b_r};
              state_r <= LIQ_FIN;
            end
          end
        end
        LIQ_WR:
        begin
          // interlocked link writes: entry fwd, entry back, old head back
          if (mem_ack)
          begin
            step_r <= step_r + 3'h1;
            unique case (step_r)
              3'h0:
              begin
                mem_addr  <= opa_r + `LIQ_BACK_OFS;
                mem_wdata <= ent_b_r;
              end
              3'h1:
              begin
                mem_addr  <= opb_r + snap_r + `LIQ_BACK_OFS;
                mem_wdata <= opa_r - (opb_r + snap_r);
              end
              default:
              begin
                // new header forward link, busy flag cleared in same write
                mem_addr  <= opb_r;
                mem_wdata <= opa_r - opb_r;
                state_r   <= LIQ_CLR;
              end
            endcase
          end
        end
        LIQ_CLR:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            if (fault_r == `LIQ_FLT_NONE)
              cc_r <= {1'b0, ent_f_r == ent_b_r, 2'b00};
            state_r <= LIQ_FIN;
          end
        end
        LIQ_FIN:
        begin
          done_r  <= 1'b1;
          state_r <= LIQ_IDLE;
        end
        default:
          state_r <= LIQ_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== test/iqi_monitor.sv ====
/*
  iqi_monitor.sv: concurrent checks on the engine's memory port.
  assumes: bound into liq_engine; one clock, synchronous active-low reset.
*/
`default_nettype none
module iqi_monitor
  import liq_pkg::*;
(
  input wire logic        aclk,      // engine clock
  input wire logic        aresetn,   // synchronous reset, low
  input wire logic        mem_req,   // request level
  input wire logic        mem_we,    // write
  input wire logic        mem_lock,  // interlocked access
  input wire logic        mem_probe, // access check only
  input wire logic [31:0] mem_addr,  // byte address
  input wire logic [31:0] mem_wdata, // write data
  input wire logic        mem_ack,   // completion pulse
  input wire logic        mem_err,   // access failed
  input wire logic [31:0] mem_rdata  // read data
);
  liq_word_t snap_r;
  liq_word_t hdr_r;
  logic      ins_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // header snapshot and address, caught when the locked read completes
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      snap_r <= 32'h0;
      hdr_r  <= 32'h0;
    end
    else if (mem_req && mem_ack && mem_lock && !mem_we)
    begin
      snap_r <= mem_rdata;
      hdr_r  <= mem_addr;
    end
  // busy flag claimed by us: stays set until the request level drops
  always_ff @(posedge aclk)
    if (!aresetn || !mem_req)
      ins_r <= 1'b0;
    else if (mem_ack && mem_lock && mem_we && mem_wdata[0] && !snap_r[0])
      ins_r <= 1'b1;
  sequence lk_rd_s;
    mem_req && mem_ack && mem_lock && !mem_we;
  endsequence
  sequence lk_wb_s;
    mem_req && mem_lock && mem_we && mem_addr == hdr_r;
  endsequence
  lock_pair_a: assert property (lk_rd_s |=> lk_wb_s)
    else $error("locked read not followed by locked write-back");
  wb_value_a: assert property (lk_wb_s |->
    mem_wdata == ((snap_r[2:0] == 3'h0) ? (snap_r | 32'h1) : snap_r))
    else $error("write-back value wrong");
  busy_end_a: assert property ((lk_wb_s and mem_ack && snap_r[2:0] != 3'h0)
    |=> !mem_req [*3])
    else $error("work continued after busy or reserved header");
  probe_next_a: assert property ((lk_wb_s and mem_ack && snap_r[2:0] == 3'h0)
    |=> mem_req && mem_probe && !mem_lock)
    else $error("no access check after claiming busy");
  fault_restore_a: assert property ((mem_req && mem_ack && mem_probe && mem_err)
    |=> mem_req && mem_we && !mem_probe && mem_addr == hdr_r && mem_wdata == snap_r)
    else $error("failed check did not restore header");
  busy_clear_a: assert property ((ins_r && mem_req && mem_we && mem_addr == hdr_r)
    |-> !mem_wdata[0])
    else $error("final header write left busy set");
  excl_a: assert property (ins_r |-> !mem_lock)
    else $error("locked access while insert holds busy");
  req_hold_a: assert property ((mem_req && !mem_ack) |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata))
    else $error("request changed before completion");
endmodule
bind liq_engine iqi_monitor iqi_monitor_inst (.*);
`default_nettype wire

// ==== test/iqi_mem_model.sv ====
/*
  iqi_mem_model.sv: byte-addressed memory answering the engine's port.
  assumes: one request at a time; the bench preloads and inspects it.
*/
`default_nettype none
module iqi_mem_model
  import liq_pkg::*;
(
  input  wire logic        aclk,      // clock
  input  wire logic        aresetn,   // reset, low
  input  wire logic        mem_req,   // request level
  input  wire logic        mem_we,    // write
  input  wire logic        mem_lock,  // interlocked, no effect here
  input  wire logic        mem_probe, // access check only
  input  wire logic [31:0] mem_addr,  // byte address
  input  wire logic [31:0] mem_wdata, // write data
  output var  logic        mem_ack,   // completion pulse
  output var  logic        mem_err,   // access refused
  output var  logic [31:0] mem_rdata  // read data
);
  logic [7:0] bytes [liq_word_t];
  liq_word_t  err_addr = 32'hffff_fff0; // probe here is refused
  int         wait_r;
  function automatic liq_word_t rd32(input liq_word_t a);
    for (int i = 3; i >= 0; i--)
      rd32 = {rd32[23:0], bytes.exists(a + i) ? bytes[a + i] : 8'h00};
  endfunction
  function automatic void wr32(input liq_word_t a, input liq_word_t d);
    for (int i = 0; i < 4; i++)
      bytes[a + i] = d[8 * i +: 8];
  endfunction
  // random 0..3 cycle wait so prompt and slow answers both occur
  always @(posedge aclk)
  begin
    mem_ack   <= 1'b0;
    mem_err   <= 1'b0;
    mem_rdata <= ~mem_rdata; // no stale data between answers
    if (!aresetn)
    begin
      wait_r    <= 0;
      mem_rdata <= 32'h0;
    end
    else if (mem_req && !mem_ack && wait_r > 0)
      wait_r <= wait_r - 1;
    else if (mem_req && !mem_ack)
    begin
      mem_ack   <= 1'b1;
      mem_err   <= mem_probe && mem_addr == err_addr;
      mem_rdata <= rd32(mem_addr);
      if (mem_we && !mem_probe)
        wr32(mem_addr, mem_wdata);
      wait_r <= $urandom % 4;
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_interlocked_queue_insert.sv ====
/*
  tb_interlocked_queue_insert.sv: axi4-lite driver, read checker, memory partner.
  assumes: engine, monitor and memory model compiled before it.
*/
`default_nettype none
`include "liq_defs.svh"
module tb_interlocked_queue_insert
  import liq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {liq_word_t exp; liq_word_t msk;} iqi_note_s;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic mem_req, mem_we, mem_lock, mem_probe, mem_ack, mem_err;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  iqi_note_s notes[$];
  iqi_note_s nt;
  int error_cnt = 0, total_checks = 0;
  liq_word_t h, e1, e2, e3, hv, d;
  always #2 aclk = ~aclk;
  liq_engine liq_engine_inst (.*);
  iqi_mem_model iqi_mem_model_inst (.*);
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic lost();
    error_cnt++;
    test_done();
  endtask
  task automatic chk(input string what, input liq_word_t seen, input liq_word_t exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic mchk(input liq_word_t a, input liq_word_t e);
    chk("memory", iqi_mem_model_inst.rd32(a), e);
  endtask
  task automatic wr(input logic [7:0] a, input liq_word_t v);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready) && n < 200);
    // bready stays high: dropping it here would meet the next call's raise
    chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
    if (n >= 200) lost();
  endtask
  task automatic rd(input logic [7:0] a, input liq_word_t e, input liq_word_t m,
                    output liq_word_t v);
    int n;
    n = 0;
    notes.push_back(iqi_note_s'{e, m});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready) && n < 200);
    v = s_axi_rdata;
    chk("rresp", {30'h0, s_axi_rresp}, 32'h0);
    if (n >= 200) lost();
  endtask
  // load operands, start, poll busy until the engine finishes
  task automatic run(input logic [7:0] op, input liq_word_t a, input liq_word_t b);
    liq_word_t v;
    int n;
    n = 0;
    wr(`LIQ_OFF_OPA, a);
    wr(`LIQ_OFF_OPB, b);
    // opcode lands first: a start in the same write still decodes the old opcode
    wr(`LIQ_OFF_CTRL, {16'h0, op, 8'h00});
    wr(`LIQ_OFF_CTRL, {16'h0, op, 8'h01});
    do
    begin
      rd(`LIQ_OFF_STATUS, 32'h0, 32'h0, v);
      n++;
    end
    while (v[`LIQ_ST_BUSY] && n < 100);
    if (n >= 100) lost();
  endtask
  task automatic res(input logic [3:0] cc, input logic [3:0] ccm, input logic [1:0] flt);
    liq_word_t v;
    rd(`LIQ_OFF_CC, {28'h0, cc}, {28'h0, ccm}, v);
    rd(`LIQ_OFF_FAULT, {30'h0, flt}, 32'h3, v);
  endtask
  // each read answer is compared with the oldest note
  always @(posedge aclk)
    if (s_axi_rvalid && s_axi_rready)
    begin
      if (notes.size() == 0) chk("note", 32'h0, 32'h1);
      else
      begin
        nt = notes.pop_front();
        chk("read", s_axi_rdata & nt.msk, nt.exp & nt.msk);
      end
    end
  initial
  begin
    void'($urandom(10225));
    h  = 32'h0000_1000 + (($urandom % 64) << 3);
    e1 = h + 32'h100;
    e2 = h + 32'h200;
    e3 = h + 32'h300;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`LIQ_OFF_STATUS, 32'h0, 32'hffff_ffff, d);
    rd(`LIQ_OFF_CC, 32'h0, 32'hffff_ffff, d);
    rd(8'h3c, 32'h0, 32'hffff_ffff, d);
    // empty queue, then a second entry at the head
    run(8'h5c, e1, h);
    res(4'b0100, 4'hf, 2'h0);
    mchk(h, e1 - h);
    mchk(h + 4, e1 - h);
    mchk(e1, h - e1);
    mchk(e1 + 4, h - e1);
    run(8'h5c, e2, h);
    res(4'b0000, 4'hf, 2'h0);
    mchk(h, e2 - h);
    mchk(e2, e1 - e2);
    mchk(e2 + 4, h - e2);
    mchk(e1 + 4, e2 - e1);
    hv = e2 - h;
    // busy flag already set by another user
    iqi_mem_model_inst.wr32(h, hv | 32'h1);
    run(8'h5c, e3, h);
    res(4'b0001, 4'hf, 2'h0);
    mchk(h, hv | 32'h1);
    iqi_mem_model_inst.wr32(h, hv);
    // reserved operands leave the queue alone
    run(8'h5c, e3 + 32'h4, h);
    res(4'h0, 4'h0, 2'h1);
    run(8'h5c, e3, h + 32'h1);
    res(4'h0, 4'h0, 2'h1);
    run(8'h5c, h, h);
    res(4'h0, 4'h0, 2'h1);
    iqi_mem_model_inst.wr32(h, hv | 32'h2);
    run(8'h5c, e3, h);
    res(4'h0, 4'h0, 2'h1);
    mchk(h, hv | 32'h2);
    iqi_mem_model_inst.wr32(h, hv);
    // entry not writable: fault with header restored
    iqi_mem_model_inst.err_addr = e3;
    run(8'h5c, e3, h);
    res(4'h0, 4'h0, 2'h2);
    mchk(h, hv);
    mchk(e3, 32'h0);
    iqi_mem_model_inst.err_addr = 32'hffff_fff0;
    run(8'h5d, e3, h);
    res(4'h0, 4'h0, 2'h3);
    // plain insert and remove at odd byte addresses, at the head only
    iqi_mem_model_inst.wr32(32'h2001, 32'h2105);
    iqi_mem_model_inst.wr32(32'h2005, 32'h2105);
    iqi_mem_model_inst.wr32(32'h2105, 32'h2001);
    iqi_mem_model_inst.wr32(32'h2109, 32'h2001);
    run(8'h0e, 32'h2203, 32'h2001);
    mchk(32'h2203, 32'h2105);
    mchk(32'h2207, 32'h2001);
    mchk(32'h2109, 32'h2203);
    mchk(32'h2001, 32'h2203);
    res(4'h0, 4'hf, 2'h0);
    run(8'h0f, 32'h2203, 32'h0);
    mchk(32'h2001, 32'h2105);
    mchk(32'h2109, 32'h2001);
    repeat (2) @(posedge aclk);
    test_done();
  end
endmodule
`default_nettype wire
